// ---- rtl/wdt_top.sv ----
`timescale 1ns/1ps
module wdt_top
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  // Software commands, one-cycle pulses
  input  wire logic                 service_i,
  input  wire logic                 watchdog_disable_cmd_i,
  input  wire logic                 watchdog_enable_cmd_i,
  // Configuration write
  input  wire logic                 cfg_wr_i,
  input  wire logic [WDT_WIDTH-1:0] wd_reload_value_i,
  input  wire logic                 cfg_sel_slow_i,
  // Status and requests
  output logic                      prewarn_irq_o,
  output logic                      reset_req_o,
  output logic                      wd_enabled_o,
  output logic [WDT_WIDTH-1:0]      wd_count_o
);

  wdt_state_type          state;
  wdt_state_type          next_state;
  logic [WDT_WIDTH-1:0]   count;
  logic [WDT_WIDTH-1:0]   reload;
  logic                   sel_slow;
  logic [7:0]             warn_cnt;
  logic                   tick_run;
  logic                   overflow;

  wdt_presc_if pif();

  wdt_prescaler u_presc
  (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pif       (pif)
  );

  // Prescaler only advances while monitoring; service restarts it
  assign pif.clear    = service_i;
  assign pif.run      = (state == ST_RUN);
  assign pif.sel_slow = sel_slow;

  // The tick is registered in the prescaler, so gate it with the present state
  assign tick_run = pif.tick && (state == ST_RUN);
  // A service in the same cycle as the last tick still rescues the interval
  assign overflow = tick_run && (count == COUNT_TOP) && !service_i;

  // Reload value and prescaler selection
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      reload   <= RELOAD_RESET;
      sel_slow <= SEL_RESET;
    end
    else if (cfg_wr_i)
    begin
      reload   <= wd_reload_value_i;
      sel_slow <= cfg_sel_slow_i;
    end
  end

  // Watchdog counter; servicing by software keeps it from the top
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      count <= RELOAD_RESET;
    end
    else if (service_i)
    begin
      count <= reload;
    end
    else if (tick_run)
    begin
      count <= count + 16'h0001;
    end
  end

  // Enable wins over disable in the same cycle, the fail-safe choice;
  // an enable while already running must not mask an overflow in that cycle
  always_comb
  begin
    next_state = state;
    if (watchdog_enable_cmd_i && (state == ST_OFF))
    begin
      next_state = ST_RUN;
    end
    else if (watchdog_disable_cmd_i && !watchdog_enable_cmd_i)
    begin
      next_state = ST_OFF;
    end
    else
    begin
      case (state)
        ST_RUN:
        begin
          if (overflow)
          begin
            next_state = ST_WARN;
          end
        end
        ST_WARN:
        begin
          if (warn_cnt == WARN_ZERO)
          begin
            next_state = ST_RESET;
          end
        end
        ST_RESET:
        begin
          next_state = ST_RESET;
        end
        default:
        begin
          next_state = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_RUN;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Time between prewarning and reset request, for the handler to save state
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      warn_cnt <= WARN_LAST;
    end
    else if (state != ST_WARN)
    begin
      warn_cnt <= WARN_LAST;
    end
    else if (warn_cnt != WARN_ZERO)
    begin
      warn_cnt <= warn_cnt - 8'h01;
    end
  end

  // Outputs registered from the next state so they line up with the state
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      prewarn_irq_o <= 1'b0;
      reset_req_o   <= 1'b0;
      wd_enabled_o  <= 1'b1;
    end
    else
    begin
      prewarn_irq_o <= (state == ST_RUN) && (next_state == ST_WARN);
      reset_req_o   <= (next_state == ST_RESET);
      wd_enabled_o  <= (next_state != ST_OFF);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      wd_count_o <= RELOAD_RESET;
    end
    else if (service_i)
    begin
      wd_count_o <= reload;
    end
    else if (tick_run)
    begin
      wd_count_o <= count + 16'h0001;
    end
  end

  chk_reset_enabled: assert property (@(posedge clk_sys_i)
    !rst_n_i |=> wd_enabled_o && !reset_req_o && !prewarn_irq_o)
    else $error("watchdog not enabled after reset");

  chk_disable_cmd: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (watchdog_disable_cmd_i && !watchdog_enable_cmd_i) |=> !wd_enabled_o && !reset_req_o)
    else $error("disable command not obeyed");

  chk_enable_cmd: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    watchdog_enable_cmd_i |=> wd_enabled_o)
    else $error("enable command not obeyed");

  chk_warn_first: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (overflow && !watchdog_enable_cmd_i && !watchdog_disable_cmd_i)
      |=> prewarn_irq_o && !reset_req_o ##1 !prewarn_irq_o)
    else $error("overflow without prewarning");

  chk_req_after_warn: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    prewarn_irq_o |-> ##[1:200] (reset_req_o || !wd_enabled_o))
    else $error("no reset request after prewarning");

  chk_req_needs_warn: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(reset_req_o) |-> $past(state) == ST_WARN)
    else $error("reset request without prewarning phase");

  chk_count_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (tick_run && !service_i) |=> count == $past(count) + 16'h0001)
    else $error("counter did not advance on tick");

  chk_service_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    service_i |=> (count == $past(reload)) && (wd_count_o == count))
    else $error("service did not reload counter");

  chk_hold_disabled: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state == ST_OFF && !service_i && !watchdog_enable_cmd_i)
      |=> $stable(count) && !prewarn_irq_o && !reset_req_o)
    else $error("disabled watchdog moved or requested");

  chk_default_reload: assert property (@(posedge clk_sys_i)
    !rst_n_i |=> (reload == RELOAD_RESET) && (sel_slow == SEL_RESET) && (count == RELOAD_RESET))
    else $error("wrong reset defaults");

endmodule : wdt_top

// ---- shared/wdt_pkg.sv ----
package wdt_pkg;

  // Counter and prescaler widths
  localparam int WDT_WIDTH   = 16;
  localparam int PRESC_WIDTH = 14;

  // Prescaler terminal counts: divide by 256 or by 16,384
  localparam logic [PRESC_WIDTH-1:0] PRESC_LAST_FAST = 14'h00ff;
  localparam logic [PRESC_WIDTH-1:0] PRESC_LAST_SLOW = 14'h3fff;
  localparam logic [PRESC_WIDTH-1:0] PRESC_ZERO      = 14'h0000;

  // Counter values
  localparam logic [WDT_WIDTH-1:0] COUNT_TOP = 16'hffff;

  // Reset defaults: 254 ticks of 256 clocks is 65,024 cycles, about 6.5 ms at 10 MHz
  localparam logic [WDT_WIDTH-1:0] RELOAD_RESET = 16'hff02;
  localparam logic                 SEL_RESET    = 1'b0;

  // Clock and prewarning time
  localparam int CLK_PERIOD_NS = 100;
  localparam int WARN_TIME_NS  = 12800;
  localparam int WARN_CYCLES   = (WARN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] WARN_LAST = 8'(WARN_CYCLES - 1);
  localparam logic [7:0] WARN_ZERO = 8'h00;

  // Gray-coded along run, warn, reset
  typedef enum logic [1:0]
  {
    ST_RUN   = 2'b00,
    ST_WARN  = 2'b01,
    ST_RESET = 2'b11,
    ST_OFF   = 2'b10
  } wdt_state_type;

  // Terminal count of the prescaler for a given selection
  function automatic logic [PRESC_WIDTH-1:0] wdt_presc_last(input logic sel_slow);
    wdt_presc_last = sel_slow ? PRESC_LAST_SLOW : PRESC_LAST_FAST;
  endfunction : wdt_presc_last

endpackage : wdt_pkg

// ---- shared/wdt_presc_if.sv ----
`timescale 1ns/1ps
interface wdt_presc_if;
  logic clear;
  logic run;
  logic sel_slow;
  logic tick;

  modport ctrl
  (
    output clear,
    output run,
    output sel_slow,
    input  tick
  );

  modport presc
  (
    input  clear,
    input  run,
    input  sel_slow,
    output tick
  );
endinterface : wdt_presc_if

// ---- rtl/wdt_prescaler.sv ----
`timescale 1ns/1ps
module wdt_prescaler
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Control from the watchdog core
  wdt_presc_if.presc pif
);

  logic [PRESC_WIDTH-1:0] cnt;

  // A selection change mid-interval is caught by the >= compare
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      cnt      <= PRESC_ZERO;
      pif.tick <= 1'b0;
    end
    else if (pif.clear)
    begin
      cnt      <= PRESC_ZERO;
      pif.tick <= 1'b0;
    end
    else if (pif.run)
    begin
      if (cnt >= wdt_presc_last(pif.sel_slow))
      begin
        cnt      <= PRESC_ZERO;
        pif.tick <= 1'b1;
      end
      else
      begin
        cnt      <= cnt + 14'h0001;
        pif.tick <= 1'b0;
      end
    end
    else
    begin
      // Keep a pending tick so a disable on the terminal count cannot swallow it
      pif.tick <= pif.tick;
    end
  end

  chk_clear_zeroes: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    pif.clear |=> (cnt == PRESC_ZERO) && !pif.tick)
    else $error("prescaler not cleared by service");

  chk_tick_period: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(pif.tick) |-> ($past(cnt) >= wdt_presc_last($past(pif.sel_slow))))
    else $error("prescaler tick before terminal count");

endmodule : wdt_prescaler

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  import wdt_pkg::*;

  typedef struct
  {
    logic [WDT_WIDTH-1:0] rld;
    logic                 slow;
    int                   cyc;
  } wdt_row_type;

  logic                 clk_sys_i = 1'b0;
  logic                 rst_n_i   = 1'b0;
  logic                 service   = 1'b0;
  logic                 dis_cmd   = 1'b0;
  logic                 en_cmd    = 1'b0;
  logic                 cfg_wr    = 1'b0;
  logic [WDT_WIDTH-1:0] reload    = 16'h0000;
  logic                 sel_slow  = 1'b0;
  logic                 prewarn;
  logic                 reset_req;
  logic                 enabled;
  logic [WDT_WIDTH-1:0] count;
  int                   n_errors  = 0;
  int                   checks    = 0;
  int                   cyc;
  // Ordinary cases: reload value, select, cycles from service to prewarning
  wdt_row_type          rows [3]  = '{'{16'hffff, 1'b0, 256}, '{16'hfffe, 1'b0, 512},
                                      '{16'hffff, 1'b1, 16384}};

  always #50 clk_sys_i = ~clk_sys_i;

  wdt_top dut
  (
    .clk_sys_i              (clk_sys_i),
    .rst_n_i                (rst_n_i),
    .service_i              (service),
    .watchdog_disable_cmd_i (dis_cmd),
    .watchdog_enable_cmd_i  (en_cmd),
    .cfg_wr_i               (cfg_wr),
    .wd_reload_value_i      (reload),
    .cfg_sel_slow_i         (sel_slow),
    .prewarn_irq_o          (prewarn),
    .reset_req_o            (reset_req),
    .wd_enabled_o           (enabled),
    .wd_count_o             (count)
  );

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : chk_rng

  // Outputs are sampled 1 ns after the edge so the edge's updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : step

  // One-cycle command: 0 service, 1 disable, 2 enable, 3 configuration write
  task automatic pulse(input int k);
    @(posedge clk_sys_i);
    case (k)
      0: service <= 1'b1;
      1: dis_cmd <= 1'b1;
      2: en_cmd <= 1'b1;
      default: cfg_wr <= 1'b1;
    endcase
    @(posedge clk_sys_i);
    {service, dis_cmd, en_cmd, cfg_wr} <= 4'h0;
    #1;
  endtask : pulse

  // Bounded wait for prewarning (0) or reset request (1), in cycles
  task automatic wait_evt(input bit rq, output int n);
    n = 0;
    do
    begin
      step(1);
      n++;
    end
    while (!((rq ? reset_req : prewarn) === 1'b1) && n < 70000);
  endtask : wait_evt

  task automatic do_reset();
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    #1;
  endtask : do_reset

  initial
  begin
    do_reset();
    chk("enabled", 16'h0001, 16'(enabled));
    chk("count", RELOAD_RESET, count);
    chk("requests", 16'h0000, 16'({prewarn, reset_req}));
    wait_evt(1'b0, cyc);
    chk_rng("default interval", 65024, 65030, cyc);
    step(1);
    chk("prewarn pulse", 16'h0000, 16'({prewarn, reset_req}));
    chk("wrapped", 16'h0000, count);
    wait_evt(1'b1, cyc);
    chk_rng("warn to reset", 126, 129, cyc);
    pulse(1);
    chk("disable", 16'h0000, 16'({enabled, reset_req}));
    foreach (rows[i])
    begin
      pulse(2);
      @(posedge clk_sys_i);
      reload   <= rows[i].rld;
      sel_slow <= rows[i].slow;
      pulse(3);
      pulse(0);
      chk("reload", rows[i].rld, count);
      wait_evt(1'b0, cyc);
      chk_rng("overflow", rows[i].cyc - 1, rows[i].cyc + 3, cyc);
      pulse(1);
    end
    pulse(2);
    chk("enable", 16'h0001, 16'(enabled));
    @(posedge clk_sys_i);
    reload   <= 16'hff00;
    sel_slow <= 1'b0;
    pulse(3);
    pulse(0);
    step(300);
    chk("count up", 16'hff01, count);
    pulse(1);
    step(1000);
    chk("held", 16'hff01, count);
    chk("quiet", 16'h0000, 16'({prewarn, reset_req}));
    pulse(2);
    step(100);
    pulse(0);
    chk("service", 16'hff00, count);
    // A prescaler left running would tick well inside this span
    step(250);
    chk("prescaler cleared", 16'hff00, count);
    step(20);
    chk("tick", 16'hff01, count);
    pulse(1);
    do_reset();
    chk("enabled again", 16'h0001, 16'(enabled));
    chk("count again", RELOAD_RESET, count);
    conclude();
  end

  initial
  begin
    // The tests take about 84,000 cycles; stop at 95,000, short of 100,000
    #9_500_000;
    n_errors++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    conclude();
  end
endmodule : tb
